// ==== bench/ebpic_far.sv ====
/*
 Far side of the pins: host, held levels and toggling floating data on the address and
 data wires. Assumes the pad triples of ebpic_top and the bench clock.
*/
`timescale 1ns/1ps
module ebpic_far import ebpic_pkg::*; (
	// Clock
	input  wire logic            mclk,
	// Pads
	input  wire ebpic_addr_pad_t apad,
	input  wire ebpic_data_pad_t dpad,
	input  wire logic            wide,
	input  wire logic            keep_en,
	// Host values
	input  wire logic [LOW_W-1:0]  h_addr,
	input  wire logic [DATA_W-1:0] h_data,
	// Resolved wires
	output logic [ADDR_W-1:0]    addr_w,
	output logic [DATA_W-1:0]    data_w
);
	logic [DATA_W-1:0] tg_q = 16'h5a5a;

	// Floating data without keeper has no stable level
	always_ff @(posedge mclk) begin
		tg_q <= ~tg_q;
	end
	// Host drives low lines in wide mode; keeper holds the rest
	assign addr_w = (apad.addr_oe & apad.addr_o) | (~apad.addr_oe &
		(wide ? {apad.addr_o[ADDR_W-1:LOW_W], h_addr} : apad.addr_o));
	assign data_w = (dpad.data_oe & dpad.data_o) | (~dpad.data_oe &
		(wide ? h_data : (keep_en ? dpad.data_o : tg_q)));
endmodule

// ==== bench/tb.sv ====
/*
 Self-checking bench for ebpic_top with the far-side model.
 Assumes a 100 MHz clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
`define WAITF(c) begin n = 0; while (!(c) && n < 60) begin @(negedge mclk); n++; end \
	if (!(c)) begin failures++; $display("BAD wait exp 1 got 0"); conclude(); end end
module tb import ebpic_pkg::*; ;
	logic mclk = 0, reset = 1, device_reset_n = 1, offline_n = 1, wide = 0, hold_req_n = 1;
	logic hold_ack_n, irq_pending, nmi_pending, core_halted, irq_take = 0, nmi_n = 1;
	logic irq_acknowledge_out, irq_acknowledge_oe, host_port_drive = 0, keep = 1;
	logic global_irq_mode_bit = 0, blocked = 0, ack_seen = 0;
	logic [NUM_IRQ-1:0] irq_mask_reg = 4'hf, irq_flag_clr = 4'h0, ext_user_irq_n = 4'hf;
	logic [NUM_IRQ-1:0] irq_flag_reg;
	logic [DATA_W-1:0]  core_rdata, host_port_rdata, host_port_wdata = 16'h0, h_data = 16'h0;
	logic [DATA_W-1:0]  last_d, data_w;
	logic [LOW_W-1:0]   host_port_addr, h_addr = 16'h0, v;
	logic [ADDR_W-1:0]  pc_q, addr_w, ka = '0;
	logic [61:0]        w;
	ebpic_req_t         core_req = '0;
	ebpic_addr_pad_t    ext_address_pad;
	ebpic_data_pad_t    ext_data_pad;
	logic [61:0]        wq[$];
	logic [LOW_W-1:0]   vq[$];
	integer seed = 32'hc86c8213;
	int failures = 0, samples_checked = 0, n;

	always #5 mclk = ~mclk;

	ebpic_top DUT (.mclk(mclk), .reset(reset), .device_reset_n(device_reset_n),
		.offline_n(offline_n), .host_port_wide_select(wide), .hold_req_n(hold_req_n),
		.hold_ack_n(hold_ack_n), .core_req(core_req), .core_rdata(core_rdata),
		.host_port_addr(host_port_addr), .host_port_rdata(host_port_rdata),
		.host_port_wdata(host_port_wdata), .host_port_drive(host_port_drive),
		.data_keeper_en(keep), .irq_mask_reg(irq_mask_reg),
		.global_irq_mode_bit(global_irq_mode_bit), .irq_flag_clr(irq_flag_clr),
		.irq_take(irq_take), .irq_flag_reg(irq_flag_reg), .irq_pending(irq_pending),
		.nmi_pending(nmi_pending), .pc_q(pc_q), .core_halted(core_halted),
		.ext_user_irq_n(ext_user_irq_n), .nmi_n(nmi_n),
		.irq_acknowledge_out(irq_acknowledge_out), .irq_acknowledge_oe(irq_acknowledge_oe),
		.ext_address_lines_i(addr_w), .ext_address_pad(ext_address_pad),
		.ext_data_lines_i(data_w), .ext_data_pad(ext_data_pad));
	ebpic_far FAR (.mclk(mclk), .apad(ext_address_pad), .dpad(ext_data_pad), .wide(wide),
		.keep_en(keep), .h_addr(h_addr), .h_data(h_data), .addr_w(addr_w), .data_w(data_w));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude();
		if (failures == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Request held until the next call or idle
	task automatic wr(input ebpic_space_t sp, input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] d;
		logic [ADDR_W-1:0] oe;
		d = DATA_W'($random(seed));
		oe = (sp == EBPIC_SP_PROG) ? {ADDR_W{1'b1}} : {{HIGH_W{1'b0}}, {LOW_W{1'b1}}};
		@(negedge mclk);
		core_req = '{1'b1, 1'b1, sp, a, d};
		if (!blocked) begin
			wq.push_back({oe, a & oe, d});
			ka = (ka & ~oe) | (a & oe);
			last_d = d;
		end
	endtask
	task automatic idle();
		@(negedge mclk);
		core_req = '0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic pulse(input logic [NUM_IRQ-1:0] u, input logic nm);
		@(negedge mclk);
		ext_user_irq_n = ~u;
		nmi_n = ~nm;
		repeat (3) @(negedge mclk);
		ext_user_irq_n = 4'hf;
		nmi_n = 1'b1;
	endtask
	task automatic take(input logic [LOW_W-1:0] vec);
		vq.push_back(vec);
		@(negedge mclk);
		irq_take = 1'b1;
		@(negedge mclk);
		irq_take = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	function automatic logic [LOW_W-1:0] uv(input int i);
		return VEC_BASE + USER_VEC_OFS + VEC_STRIDE * LOW_W'(i);
	endfunction

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(negedge mclk) begin
		if (!reset && !wide && ext_data_pad.data_oe !== DATA_ZERO) begin
			w = (wq.size() > 0) ? wq.pop_front() : '1;
			`CHK("write pins", w, {ext_address_pad.addr_oe, ext_address_pad.addr_o & ext_address_pad.addr_oe, ext_data_pad.data_o})
		end
		// Vector shows the cycle after the acknowledge
		if (ack_seen) begin
			v = (vq.size() > 0) ? vq.pop_front() : 16'h0;
			`CHK("vector", v, ext_address_pad.addr_o[LOW_W-1:0])
			`CHK("vector pc", {{HIGH_W{1'b0}}, v}, pc_q)
		end
		ack_seen = (irq_acknowledge_out === 1'b0);
	end

	initial begin
		repeat (100000) @(posedge mclk);
		failures++;
		conclude();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(negedge mclk);
		reset = 1'b0;
		`WAITF(core_halted === 1'b0)
		for (int s = 0; s < 3; s++) wr(ebpic_space_t'(s), ADDR_W'($random(seed)));
		wr(EBPIC_SP_PROG, 23'h7fffff);
		wr(EBPIC_SP_DATA, 23'h000000);
		idle();
		`CHK("data oe idle", DATA_ZERO, ext_data_pad.data_oe)
		`CHK("data keeper", last_d, data_w)
		// Read takes the held bus level and leaves the bus floating
		ka = {ka[ADDR_W-1:LOW_W], LOW_W'($random(seed))};
		@(negedge mclk);
		core_req = '{1'b1, 1'b0, EBPIC_SP_DATA, ka, DATA_ZERO};
		@(negedge mclk);
		core_req = '0;
		`CHK("read data", last_d, core_rdata)
		`CHK("read float", DATA_ZERO, ext_data_pad.data_oe)
		// Outside master takes the bus
		hold_req_n = 1'b0;
		`WAITF(hold_ack_n === 1'b0)
		blocked = 1'b1;
		wr(EBPIC_SP_PROG, 23'h123456);
		idle();
		`CHK("addr oe hold", ADDR_ZERO, ext_address_pad.addr_oe)
		`CHK("data oe hold", DATA_ZERO, ext_data_pad.data_oe)
		`CHK("addr keeper", ka, addr_w)
		hold_req_n = 1'b1;
		`WAITF(hold_ack_n === 1'b1)
		offline_n = 1'b0;
		`WAITF(irq_acknowledge_oe === 1'b0)
		wr(EBPIC_SP_DATA, 23'h00abcd);
		idle();
		`CHK("offline oe", {ADDR_ZERO, DATA_ZERO}, {ext_address_pad.addr_oe, ext_data_pad.data_oe})
		offline_n = 1'b1;
		blocked = 1'b0;
		`WAITF(irq_acknowledge_oe === 1'b1)
		// Wide host mode
		wide = 1'b1;
		h_addr = LOW_W'($random(seed));
		h_data = DATA_W'($random(seed));
		repeat (4) @(negedge mclk);
		`CHK("host addr oe", 16'h0000, ext_address_pad.addr_oe[LOW_W-1:0])
		`CHK("host addr", h_addr, host_port_addr)
		`CHK("host rdata", h_data, host_port_rdata)
		host_port_wdata = DATA_W'($random(seed));
		host_port_drive = 1'b1;
		`WAITF(ext_data_pad.data_oe === 16'hffff)
		`CHK("host wdata", host_port_wdata, ext_data_pad.data_o)
		host_port_drive = 1'b0;
		repeat (3) @(negedge mclk);
		wide = 1'b0;
		// User interrupts one by one, then two together
		for (int i = 0; i < NUM_IRQ; i++) begin
			pulse(4'h1 << i, 1'b0);
			`WAITF(irq_flag_reg[i] === 1'b1)
			`CHK("pending", 1'b1, irq_pending)
			take(uv(i));
			`CHK("flags taken", IRQ_ZERO, irq_flag_reg)
		end
		pulse(4'ha, 1'b0);
		`WAITF(irq_flag_reg === 4'ha)
		take(uv(1));
		take(uv(3));
		irq_mask_reg = 4'hb;
		pulse(4'h4, 1'b0);
		`WAITF(irq_flag_reg[2] === 1'b1)
		`CHK("masked", 1'b0, irq_pending)
		irq_mask_reg = 4'hf;
		global_irq_mode_bit = 1'b1;
		@(negedge mclk);
		`CHK("global off", 1'b0, irq_pending)
		global_irq_mode_bit = 1'b0;
		@(negedge mclk);
		`CHK("global on", 1'b1, irq_pending)
		irq_flag_clr = 4'h4;
		@(negedge mclk);
		irq_flag_clr = 4'h0;
		@(negedge mclk);
		`CHK("flag cleared", IRQ_ZERO, irq_flag_reg)
		// Non-maskable under full masking
		global_irq_mode_bit = 1'b1;
		irq_mask_reg = 4'h0;
		pulse(4'h0, 1'b1);
		`WAITF(nmi_pending === 1'b1)
		take(VEC_BASE + NMI_VEC_OFS);
		`CHK("nmi served", 1'b0, nmi_pending)
		// Device reset pin
		device_reset_n = 1'b0;
		`WAITF(core_halted === 1'b1)
		repeat (2) @(negedge mclk);
		`CHK("pc in reset", RESET_VECTOR, pc_q)
		`CHK("data oe reset", DATA_ZERO, ext_data_pad.data_oe)
		device_reset_n = 1'b1;
		`WAITF(core_halted === 1'b0)
		`CHK("pc after reset", RESET_VECTOR, pc_q)
		wr(EBPIC_SP_IO, 23'h00ffff);
		idle();
		`CHK("queues left", 0, wq.size() + vq.size())
		conclude();
	end
endmodule

// ==== logic/ebpic_pkg.sv ====
/*
 Package for the external bus pin and interrupt front end: widths, reset
 vector, interrupt vectors and packed carriers shared by both design files.
 Assumes one core clock and nothing else.
*/
package ebpic_pkg;
	localparam int ADDR_W     = 23;
	localparam int LOW_W      = 16;
	localparam int HIGH_W     = 7;
	localparam int DATA_W     = 16;
	localparam int NUM_IRQ    = 4;
	localparam int IRQ_IDX_W  = 2;

	localparam logic [ADDR_W-1:0] RESET_VECTOR  = 23'h00ff80;
	localparam logic [LOW_W-1:0]  VEC_BASE      = 16'hff80;
	localparam logic [LOW_W-1:0]  NMI_VEC_OFS   = 16'h0008;
	localparam logic [LOW_W-1:0]  USER_VEC_OFS  = 16'h0040;
	localparam logic [LOW_W-1:0]  VEC_STRIDE    = 16'h0004;
	localparam logic [ADDR_W-1:0] ADDR_ZERO     = 23'h000000;
	localparam logic [DATA_W-1:0] DATA_ZERO     = 16'h0000;
	localparam logic [NUM_IRQ-1:0] IRQ_ZERO     = 4'h0;

	// Bus target spaces
	typedef enum logic [1:0] {
		EBPIC_SP_PROG = 2'b00,
		EBPIC_SP_DATA = 2'b01,
		EBPIC_SP_IO   = 2'b10
	} ebpic_space_t;

	// Core-side bus request
	typedef struct packed {
		logic                 active;
		logic                 write;
		ebpic_space_t         space;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
	} ebpic_req_t;

	// Pad drive of one two-way group
	typedef struct packed {
		logic [ADDR_W-1:0]    addr_o;
		logic [ADDR_W-1:0]    addr_oe;
	} ebpic_addr_pad_t;

	typedef struct packed {
		logic [DATA_W-1:0]    data_o;
		logic [DATA_W-1:0]    data_oe;
	} ebpic_data_pad_t;
endpackage

// ==== logic/ebpic_sync.sv ====
/*
 Two-flop synchroniser, one per bit, for pins entering the core clock.
 Assumes the inputs are asynchronous levels; the first stage feeds only the
 second.
*/
`timescale 1ns/1ps
module ebpic_sync import ebpic_pkg::*; #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_q   <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ==== logic/ebpic_top.sv ====
/*
 External address/data pin control and external interrupt front end.
 Assumes a core that issues bus requests and interrupt clears on mclk, and a
 pad ring that resolves output/enable/input triples into wires.
*/
`timescale 1ns/1ps
module ebpic_top import ebpic_pkg::*; (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 device_reset_n,
	// Mode pins
	input  wire logic                 offline_n,
	input  wire logic                 host_port_wide_select,
	input  wire logic                 hold_req_n,
	output logic                      hold_ack_n,
	// Core bus request
	input  wire ebpic_req_t           core_req,
	output logic [DATA_W-1:0]         core_rdata,
	output logic [LOW_W-1:0]          host_port_addr,
	output logic [DATA_W-1:0]         host_port_rdata,
	input  wire logic [DATA_W-1:0]    host_port_wdata,
	input  wire logic                 host_port_drive,
	// Control bits
	input  wire logic                 data_keeper_en,
	input  wire logic [NUM_IRQ-1:0]   irq_mask_reg,
	input  wire logic                 global_irq_mode_bit,
	input  wire logic [NUM_IRQ-1:0]   irq_flag_clr,
	input  wire logic                 irq_take,
	output logic [NUM_IRQ-1:0]        irq_flag_reg,
	output logic                      irq_pending,
	output logic                      nmi_pending,
	output logic [ADDR_W-1:0]         pc_q,
	output logic                      core_halted,
	// Interrupt pins
	input  wire logic [NUM_IRQ-1:0]   ext_user_irq_n,
	input  wire logic                 nmi_n,
	output logic                      irq_acknowledge_out,
	output logic                      irq_acknowledge_oe,
	// Address pins
	input  wire logic [ADDR_W-1:0]    ext_address_lines_i,
	output ebpic_addr_pad_t           ext_address_pad,
	// Data pins
	input  wire logic [DATA_W-1:0]    ext_data_lines_i,
	output ebpic_data_pad_t           ext_data_pad
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [NUM_IRQ+3:0] pins_s;
	logic [NUM_IRQ-1:0] irq_n_s;
	logic               nmi_n_s;
	logic               rst_n_s;
	logic               hold_n_s;
	logic               off_n_s;

	ebpic_sync #(.WIDTH(NUM_IRQ+4), .INIT({(NUM_IRQ+4){1'b1}})) u_sync (
		.mclk     (mclk),
		.reset    (reset),
		.async_in ({ext_user_irq_n, nmi_n, device_reset_n, hold_req_n, offline_n}),
		.sync_out (pins_s)
	);
	assign {irq_n_s, nmi_n_s, rst_n_s, hold_n_s, off_n_s} = pins_s;

	// ------------------------------------------------------------
	// Reset, hold, program counter
	// ------------------------------------------------------------
	logic       dev_rst;
	logic       in_hold_q;
	logic       ack_q;
	logic [LOW_W-1:0] vec_q;

	assign dev_rst     = reset | ~rst_n_s;
	assign core_halted = dev_rst;

	// Hold granted only between bus requests; the bus is floated on grant
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			in_hold_q <= 1'b0;
		end else if (!hold_n_s && !core_req.active) begin
			in_hold_q <= 1'b1;
		end else if (hold_n_s) begin
			in_hold_q <= 1'b0;
		end
	end
	assign hold_ack_n = ~in_hold_q;

	// Vector fetch for a taken interrupt overrides the core's next address
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			pc_q <= RESET_VECTOR;
		end else if (ack_q) begin
			pc_q <= {{HIGH_W{1'b0}}, vec_q};
		end else if (core_req.active && core_req.space == EBPIC_SP_PROG) begin
			pc_q <= core_req.addr;
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags and priority
	// ------------------------------------------------------------
	logic [NUM_IRQ-1:0] irq_prev_q;
	logic               nmi_prev_q;
	logic [NUM_IRQ-1:0] irq_fall;
	logic [NUM_IRQ-1:0] irq_en;
	logic [IRQ_IDX_W-1:0] win_idx;
	logic [NUM_IRQ-1:0] take_onehot;
	logic               take_nmi;

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			irq_prev_q <= {NUM_IRQ{1'b1}};
			nmi_prev_q <= 1'b1;
		end else begin
			irq_prev_q <= irq_n_s;
			nmi_prev_q <= nmi_n_s;
		end
	end
	assign irq_fall = irq_prev_q & ~irq_n_s;

	assign irq_en      = irq_flag_reg & irq_mask_reg;
	assign irq_pending = |irq_en & ~global_irq_mode_bit;

	// Lowest index wins
	always_comb begin
		win_idx = '0;
		for (int i = NUM_IRQ-1; i >= 0; i--) begin
			if (irq_en[i]) begin
				win_idx = IRQ_IDX_W'(i);
			end
		end
	end

	assign take_nmi    = irq_take & nmi_pending;
	assign take_onehot = (irq_take && !nmi_pending && irq_pending) ?
		(NUM_IRQ'(1) << win_idx) : IRQ_ZERO;

	// Set wins over a clear in the same cycle
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g++) begin : g_flag
			always_ff @(posedge mclk) begin
				if (dev_rst) begin
					irq_flag_reg[g] <= 1'b0;
				end else if (irq_fall[g]) begin
					irq_flag_reg[g] <= 1'b1;
				end else if (irq_flag_clr[g] || take_onehot[g]) begin
					irq_flag_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			nmi_pending <= 1'b0;
		end else if (nmi_prev_q && !nmi_n_s) begin
			nmi_pending <= 1'b1;
		end else if (take_nmi) begin
			nmi_pending <= 1'b0;
		end
	end

	// Acknowledge pulse carries the vector address for one cycle
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			ack_q <= 1'b0;
			vec_q <= VEC_BASE;
		end else begin
			ack_q <= take_nmi | (|take_onehot);
			if (take_nmi) begin
				vec_q <= VEC_BASE + NMI_VEC_OFS;
			end else begin
				vec_q <= VEC_BASE + USER_VEC_OFS + LOW_W'(VEC_STRIDE * win_idx);
			end
		end
	end

	assign irq_acknowledge_out = ~ack_q;
	assign irq_acknowledge_oe  = off_n_s;

	// ------------------------------------------------------------
	// Address pins
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] addr_drv_q;
	logic [ADDR_W-1:0] addr_keep_q;
	logic              addr_low_oe;
	logic              addr_high_oe;
	logic              bus_float;
	logic              addr_prog_q;

	assign bus_float = ~off_n_s | in_hold_q;

	// High enable is registered with the address so both change on one edge
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			addr_drv_q  <= ADDR_ZERO;
			addr_prog_q <= 1'b0;
		end else if (ack_q) begin
			addr_drv_q  <= {{HIGH_W{1'b0}}, vec_q};
			addr_prog_q <= 1'b0;
		end else begin
			if (core_req.active) begin
				addr_drv_q <= core_req.addr;
			end
			addr_prog_q <= core_req.active && core_req.space == EBPIC_SP_PROG;
		end
	end

	assign addr_low_oe  = ~bus_float & ~host_port_wide_select;
	assign addr_high_oe = ~bus_float & addr_prog_q;

	// Keeper follows the pin while driven, then holds
	always_ff @(posedge mclk) begin
		if (reset) begin
			addr_keep_q <= ADDR_ZERO;
		end else begin
			if (addr_low_oe) begin
				addr_keep_q[LOW_W-1:0] <= addr_drv_q[LOW_W-1:0];
			end
			if (addr_high_oe) begin
				addr_keep_q[ADDR_W-1:LOW_W] <= addr_drv_q[ADDR_W-1:LOW_W];
			end
		end
	end

	assign ext_address_pad.addr_oe = {{HIGH_W{addr_high_oe}}, {LOW_W{addr_low_oe}}};
	assign ext_address_pad.addr_o  = {addr_high_oe ? addr_drv_q[ADDR_W-1:LOW_W] :
		addr_keep_q[ADDR_W-1:LOW_W], addr_low_oe ? addr_drv_q[LOW_W-1:0] :
		addr_keep_q[LOW_W-1:0]};

	// Host drives the low lines in wide host mode
	always_ff @(posedge mclk) begin
		if (reset) begin
			host_port_addr <= VEC_BASE ^ VEC_BASE;
		end else if (host_port_wide_select) begin
			host_port_addr <= ext_address_lines_i[LOW_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Data pins
	// ------------------------------------------------------------
	logic [DATA_W-1:0] data_drv_q;
	logic [DATA_W-1:0] data_keep_q;
	logic              data_oe_q;

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			data_drv_q <= DATA_ZERO;
			data_oe_q  <= 1'b0;
		end else if (host_port_wide_select) begin
			data_drv_q <= host_port_wdata;
			data_oe_q  <= host_port_drive & off_n_s & hold_n_s;
		end else begin
			data_drv_q <= core_req.wdata;
			data_oe_q  <= core_req.active & core_req.write & ~bus_float & hold_n_s;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			data_keep_q <= DATA_ZERO;
		end else if (ext_data_pad.data_oe[0]) begin
			data_keep_q <= data_drv_q;
		end
	end

	always_comb begin
		// Hold gates at once, even for a write already registered
		ext_data_pad.data_oe = {DATA_W{data_oe_q & off_n_s & hold_n_s & ~dev_rst}};
		ext_data_pad.data_o  = data_drv_q;
		if (!ext_data_pad.data_oe[0] && data_keeper_en) begin
			// Keeper drives weakly in silicon; here it only sets the level
			ext_data_pad.data_o = data_keep_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			core_rdata      <= DATA_ZERO;
			host_port_rdata <= DATA_ZERO;
		end else if (host_port_wide_select) begin
			host_port_rdata <= ext_data_lines_i;
		end else if (core_req.active && !core_req.write) begin
			core_rdata <= ext_data_lines_i;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_offline_float;
		@(posedge mclk) disable iff (reset)
		!off_n_s |-> !irq_acknowledge_oe && ext_address_pad.addr_oe == ADDR_ZERO
			&& ext_data_pad.data_oe == DATA_ZERO;
	endproperty
	a_offline_float: assert property (p_offline_float) else $error("offline not floated");

	property p_hold_float;
		@(posedge mclk) disable iff (reset)
		in_hold_q |-> ext_address_pad.addr_oe == ADDR_ZERO;
	endproperty
	a_hold_float: assert property (p_hold_float) else $error("hold not floated");

	property p_host_low_in;
		@(posedge mclk) disable iff (reset)
		host_port_wide_select |-> ext_address_pad.addr_oe[LOW_W-1:0] == 16'h0000;
	endproperty
	a_host_low_in: assert property (p_host_low_in) else $error("low lines driven");

	property p_high_prog;
		@(posedge mclk) disable iff (reset)
		ext_address_pad.addr_oe[ADDR_W-1] |->
			$past(core_req.active && core_req.space == EBPIC_SP_PROG && !ack_q);
	endproperty
	a_high_prog: assert property (p_high_prog) else $error("high lines off prog");

	property p_data_rst;
		@(posedge mclk) disable iff (reset)
		(dev_rst || !hold_n_s) |-> ext_data_pad.data_oe == DATA_ZERO;
	endproperty
	a_data_rst: assert property (p_data_rst) else $error("data driven in reset");

	property p_keep_addr;
		@(posedge mclk) disable iff (reset)
		(addr_low_oe ##1 !addr_low_oe) |->
			ext_address_pad.addr_o[LOW_W-1:0] == $past(addr_drv_q[LOW_W-1:0]);
	endproperty
	a_keep_addr: assert property (p_keep_addr) else $error("address keeper lost");

	property p_pc_reset;
		@(posedge mclk) disable iff (reset)
		dev_rst |=> pc_q == RESET_VECTOR;
	endproperty
	a_pc_reset: assert property (p_pc_reset) else $error("pc not reset vector");

	sequence s_irq_edge;
		!dev_rst && irq_fall[0] && !irq_flag_clr[0];
	endsequence
	property p_flag_set;
		@(posedge mclk) disable iff (reset)
		s_irq_edge ##1 !dev_rst |-> irq_flag_reg[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_nmi_unmasked;
		@(posedge mclk) disable iff (reset)
		(take_nmi && !dev_rst) |=> ack_q && vec_q == VEC_BASE + NMI_VEC_OFS;
	endproperty
	a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("nmi not taken");

	property p_ack_vec;
		@(posedge mclk) disable iff (reset)
		(ack_q && !dev_rst) |=> addr_drv_q[LOW_W-1:0] == $past(vec_q);
	endproperty
	a_ack_vec: assert property (p_ack_vec) else $error("vector not on lines");
endmodule
